// *** rtl/uifl_map.svh ***
`ifndef UIFL_MAP_SVH
`define UIFL_MAP_SVH

// register write addresses; the read address is the write address plus one
`define UIFL_ADDR_RX_ENABLE   8'h04
`define UIFL_ADDR_TX_ENABLE   8'h06
`define UIFL_ADDR_RX_FLAGS    8'h08
`define UIFL_ADDR_TX_FLAGS    8'h0a
`define UIFL_ADDR_CONFIG_ONE  8'h0c

// implemented bit masks (reserved bits read zero)
`define UIFL_RX_MASK          8'hbf
`define UIFL_TX_MASK          8'h3f

// field positions
`define UIFL_POR_BIT          7
`define UIFL_CFG_SE_BIT       7
`define UIFL_CFG_BAUD_HI      6
`define UIFL_CFG_BAUD_LO      5
`define UIFL_CFG_COUNT_HI     4

// reset values
`define UIFL_CFG_RESET        8'h60
`define UIFL_POR_RESET        1'b1

// link rates in bits per second
`define UIFL_RATE_500K        500000
`define UIFL_RATE_1M          1000000
`define UIFL_RATE_2M          2000000

// serial port framing
`define UIFL_BYTE_LAST        3'h7

`endif

// *** rtl/uifl_pkg.sv ***
package uifl_pkg;

  // two-bit rate selection code
  typedef enum logic [1:0] {
    UIFL_BAUD_500K_A = 2'b00,
    UIFL_BAUD_500K_B = 2'b01,
    UIFL_BAUD_1M     = 2'b10,
    UIFL_BAUD_2M     = 2'b11
  } uifl_baud_e;

  // serial port transaction phase
  typedef enum logic [1:0] {
    UIFL_ST_IDLE = 2'b00,
    UIFL_ST_ADDR = 2'b01,
    UIFL_ST_DATA = 2'b10,
    UIFL_ST_DONE = 2'b11
  } uifl_spi_e;

  // link configuration carried to the uart
  typedef struct packed {
    logic       single_ended;
    uifl_baud_e baud;
    logic [4:0] count;
  } uifl_cfg_s;

endpackage : uifl_pkg

// *** rtl/uifl_regs.sv ***
// Behaviour
// R1: rx flags error(7), busy(5), idle(4), overflow(3), full(2), stop(1), empty(0) reset to 0.
// R2: tx flags busy(5), idle(4), overflow(3), full(2), available(1), empty(0) reset to 0.
// R3: bit 6 of both flag registers ignores writes and reads zero.
// R4: transmit flag bit 7 is a power-on indicator set to one by reset.
// R5: the power-on indicator clears only when the host writes zero to it.
// R6: the power-on indicator never drives the interrupt output.
// R7: config bit 7 (reset 0) picks single-ended receive, where zero differential reads one.
// R8: the transmit output is the same in single-ended and differential modes.
// R9: configuration bits 6:5 pick the rate, 00/01 500kbps, 10 1Mbps, 11 2Mbps (reset 11).
// R10: configuration bits 4:0 reset to zero and are plain storage with no effect.
// R11: each status condition has an enable bit, reset to zero, gating its interrupt.
// R12: flags latch on a condition rising, int follows any enabled flag, a written zero clears.
// R13: each register is written at its even address and read at the next odd address.
`include "uifl_map.svh"

module uifl_regs #(
  parameter int CLK_HZ = 20000000
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rstn,
  // host serial port
  input  wire logic              i_cs_n,
  input  wire logic              i_sclk,
  input  wire logic              i_mosi,
  output logic                   o_miso,
  output logic                   o_miso_oe,
  // uart status conditions
  input  wire logic [7:0]        i_rx_status,
  input  wire logic [7:0]        i_tx_status,
  // line pins and uart bit streams
  input  wire logic              i_rx_plus_in,
  input  wire logic              i_rx_minus_in,
  input  wire logic              i_tx_bit,
  output logic                   o_rx_bit,
  output logic                   o_tx_plus,
  output logic                   o_tx_minus,
  // configuration and interrupt
  output uifl_pkg::uifl_cfg_s    o_cfg,
  output logic [15:0]            o_bit_period,
  output logic                   o_int
);
  import uifl_pkg::*;

  // the slowest divide must fit and the fastest must be at least two cycles
  if (CLK_HZ / `UIFL_RATE_2M < 2 || CLK_HZ / `UIFL_RATE_500K > 65535) begin : g_clk_check
    $error("uifl_regs: CLK_HZ cannot serve the link rates");
  end

  // clock cycles per bit for a rate code
  function automatic logic [15:0] period_of(input uifl_baud_e code);
    int rate;
    rate = `UIFL_RATE_500K;
    if (code == UIFL_BAUD_1M) begin
      rate = `UIFL_RATE_1M;
    end else if (code == UIFL_BAUD_2M) begin
      rate = `UIFL_RATE_2M;
    end
    return 16'(CLK_HZ / rate);
  endfunction : period_of

  // bit period that matches the reset rate code
  localparam logic [15:0] PERIOD_RESET = period_of(UIFL_BAUD_2M);

  // registers
  uifl_spi_e  state_ff;
  logic       sclk_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_in_ff;
  logic [7:0] shift_out_ff;
  logic [7:0] addr_ff;
  logic [7:0] rx_en_ff;
  logic [7:0] tx_en_ff;
  logic [7:0] rx_flag_ff;
  logic [7:0] tx_flag_ff;
  logic       por_ff;
  logic [7:0] cfg_ff;
  logic [7:0] rx_stat_ff;
  logic [7:0] tx_stat_ff;
  uifl_spi_e  nxt_state;

  // serial clock edges, pins taken as synchronous
  wire        sclk_rise = i_sclk & ~sclk_ff;
  wire        sclk_fall = ~i_sclk & sclk_ff;
  wire        byte_done = sclk_rise && (bit_cnt_ff == `UIFL_BYTE_LAST);
  wire  [7:0] byte_in   = {shift_in_ff[6:0], i_mosi};

  // write strobe on the last data bit of an even address
  wire        wr_cycle  = byte_done && (state_ff == UIFL_ST_DATA) && !addr_ff[0]; // R13
  wire        wr_rx_en  = wr_cycle && (addr_ff == `UIFL_ADDR_RX_ENABLE);
  wire        wr_tx_en  = wr_cycle && (addr_ff == `UIFL_ADDR_TX_ENABLE);
  wire        wr_rx_fl  = wr_cycle && (addr_ff == `UIFL_ADDR_RX_FLAGS);
  wire        wr_tx_fl  = wr_cycle && (addr_ff == `UIFL_ADDR_TX_FLAGS);
  wire        wr_cfg    = wr_cycle && (addr_ff == `UIFL_ADDR_CONFIG_ONE);

  // read decode of the odd address just received
  wire  [7:0] rd_base   = {byte_in[7:1], 1'b0};
  wire        rd_odd    = byte_in[0]; // R13
  wire  [7:0] tx_rd     = {por_ff, tx_flag_ff[6:0]};
  wire  [7:0] rd_data   = !rd_odd                               ? 8'h00 :
                          (rd_base == `UIFL_ADDR_RX_ENABLE)     ? rx_en_ff :
                          (rd_base == `UIFL_ADDR_TX_ENABLE)     ? tx_en_ff :
                          (rd_base == `UIFL_ADDR_RX_FLAGS)      ? rx_flag_ff :
                          (rd_base == `UIFL_ADDR_TX_FLAGS)      ? tx_rd :
                          (rd_base == `UIFL_ADDR_CONFIG_ONE)    ? cfg_ff : 8'h00;

  // condition rising edges latch flags; a zero written clears; set wins over clear
  wire  [7:0] rx_rise   = i_rx_status & ~rx_stat_ff & `UIFL_RX_MASK;           // R12
  wire  [7:0] tx_rise   = i_tx_status & ~tx_stat_ff & `UIFL_TX_MASK;           // R12
  wire  [7:0] rx_keep   = wr_rx_fl ? byte_in : 8'hff;
  wire  [7:0] tx_keep   = wr_tx_fl ? byte_in : 8'hff;
  wire  [7:0] nxt_rx_flag = ((rx_flag_ff & rx_keep) | rx_rise) & `UIFL_RX_MASK; // R1 R3 R12
  wire  [7:0] nxt_tx_flag = ((tx_flag_ff & tx_keep) | tx_rise) & `UIFL_TX_MASK; // R2 R3 R12
  wire        nxt_por   = por_ff & ~(wr_tx_fl & ~byte_in[`UIFL_POR_BIT]);       // R5

  // enabled flags request the interrupt; the power-on bit is left out
  wire        nxt_int   = |((nxt_rx_flag & rx_en_ff) | (nxt_tx_flag & tx_en_ff)); // R6 R11 R12

  // receive decision: single-ended treats zero differential as one
  wire        se_mode   = cfg_ff[`UIFL_CFG_SE_BIT];
  wire        rx_diff   = i_rx_plus_in & ~i_rx_minus_in;
  wire        rx_single = ~(~i_rx_plus_in & i_rx_minus_in);
  wire        nxt_rx_bit = se_mode ? rx_single : rx_diff; // R7

  // transaction phase sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      UIFL_ST_IDLE: begin
        nxt_state = UIFL_ST_ADDR;
      end
      UIFL_ST_ADDR: begin
        if (byte_done) begin
          nxt_state = UIFL_ST_DATA;
        end
      end
      UIFL_ST_DATA: begin
        if (byte_done) begin
          nxt_state = UIFL_ST_DONE;
        end
      end
      UIFL_ST_DONE: begin
        nxt_state = UIFL_ST_DONE;
      end
    endcase
    if (i_cs_n) begin
      nxt_state = UIFL_ST_IDLE;
    end
  end

  // serial port shifting
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff     <= UIFL_ST_IDLE;
      sclk_ff      <= 1'b0;
      bit_cnt_ff   <= 3'h0;
      shift_in_ff  <= 8'h00;
      shift_out_ff <= 8'h00;
      addr_ff      <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      sclk_ff  <= i_sclk;
      if (i_cs_n) begin
        bit_cnt_ff <= 3'h0;
      end else if (sclk_rise) begin
        bit_cnt_ff  <= bit_cnt_ff + 3'h1;
        shift_in_ff <= byte_in;
      end
      if (byte_done && state_ff == UIFL_ST_ADDR) begin
        addr_ff      <= byte_in;
        shift_out_ff <= rd_data;
      end else if (sclk_fall && state_ff == UIFL_ST_DATA) begin
        shift_out_ff <= {shift_out_ff[6:0], 1'b0};
      end
    end
  end

  // data out, driven only while selected
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_miso_oe <= ~i_cs_n;
      if (i_cs_n) begin
        o_miso <= 1'b0;
      end else if (sclk_fall && state_ff == UIFL_ST_DATA) begin
        o_miso <= shift_out_ff[7];
      end
    end
  end

  // enable registers
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_en_ff <= 8'h00; // R11
      tx_en_ff <= 8'h00; // R11
    end else begin
      if (wr_rx_en) begin
        rx_en_ff <= byte_in & `UIFL_RX_MASK;
      end
      if (wr_tx_en) begin
        tx_en_ff <= byte_in & `UIFL_TX_MASK;
      end
    end
  end

  // flags, power-on indicator and condition history
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_flag_ff <= 8'h00; // R1
      tx_flag_ff <= 8'h00; // R2
      por_ff     <= `UIFL_POR_RESET; // R4
      rx_stat_ff <= 8'h00;
      tx_stat_ff <= 8'h00;
      o_int      <= 1'b0;
    end else begin
      rx_flag_ff <= nxt_rx_flag;
      tx_flag_ff <= nxt_tx_flag;
      por_ff     <= nxt_por;
      rx_stat_ff <= i_rx_status;
      tx_stat_ff <= i_tx_status;
      o_int      <= nxt_int;
    end
  end

  // first configuration register
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_ff <= `UIFL_CFG_RESET; // R7 R9 R10
    end else if (wr_cfg) begin
      cfg_ff <= byte_in; // R10
    end
  end

  // line side and configuration outputs
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rx_bit     <= 1'b0;
      o_tx_plus    <= 1'b0;
      o_tx_minus   <= 1'b1;
      o_cfg        <= uifl_cfg_s'(`UIFL_CFG_RESET);
      o_bit_period <= PERIOD_RESET;
    end else begin
      o_rx_bit     <= nxt_rx_bit;
      o_tx_plus    <= i_tx_bit;  // R8
      o_tx_minus   <= ~i_tx_bit; // R8
      o_cfg        <= uifl_cfg_s'(cfg_ff);
      o_bit_period <= period_of(uifl_baud_e'(cfg_ff[`UIFL_CFG_BAUD_HI:`UIFL_CFG_BAUD_LO])); // R9
    end
  end

endmodule : uifl_regs

// *** tb/uifl_regs_sva.sv ***
module uifl_regs_sva (
  // clock, reset and serial select
  input wire logic               i_ref_clk,
  input wire logic               i_rstn,
  input wire logic               i_cs_n,
  // status and line inputs
  input wire logic [7:0]         i_rx_status,
  input wire logic [7:0]         i_tx_status,
  input wire logic               i_rx_plus_in,
  input wire logic               i_rx_minus_in,
  input wire logic               i_tx_bit,
  // outputs watched
  input wire logic               o_miso,
  input wire logic               o_miso_oe,
  input wire logic               o_rx_bit,
  input wire logic               o_tx_plus,
  input wire logic               o_tx_minus,
  input wire uifl_pkg::uifl_cfg_s o_cfg,
  input wire logic [15:0]        o_bit_period,
  input wire logic               o_int
);
  timeunit 1ns;
  timeprecision 1ns;
  import uifl_pkg::*;
  logic [7:0]  rx_ff;
  logic [7:0]  tx_ff;
  logic        rise_ff;
  logic [15:0] exp_per;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // expected bit period from the rate code
  assign exp_per = o_cfg.baud[1] ? (o_cfg.baud[0] ? 16'h000a : 16'h0014) : 16'h0028;
  // remembers any status rise that may latch a flag
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_ff   <= 8'h00;
      tx_ff   <= 8'h00;
      rise_ff <= 1'b0;
    end else begin
      rx_ff   <= i_rx_status;
      tx_ff   <= i_tx_status;
      rise_ff <= |(i_rx_status & ~rx_ff & 8'hbf) | |(i_tx_status & ~tx_ff & 8'h3f);
    end
  end
  AST_TX_LINE: assert property ($past(i_rstn) |-> o_tx_plus == $past(i_tx_bit)
    && o_tx_minus == !$past(i_tx_bit)) else $error("tx line mismatch");
  AST_RX_BIT: assert property ($past(i_rstn) && $stable(o_cfg) |-> o_rx_bit ==
    (o_cfg.single_ended ? ($past(i_rx_plus_in) | !$past(i_rx_minus_in))
    : ($past(i_rx_plus_in) & !$past(i_rx_minus_in)))) else $error("rx bit mismatch");
  AST_BIT_PERIOD: assert property ($stable(o_cfg) |-> o_bit_period == exp_per)
    else $error("bit period mismatch");
  AST_INT_RISE: assert property ($rose(o_int) |-> rise_ff || $past(rise_ff)
    || !$past(i_cs_n) || !$past(i_cs_n, 2)) else $error("int rose without cause");
  AST_INT_FALL: assert property ($fell(o_int) |-> !$past(i_cs_n) || !$past(i_cs_n, 2))
    else $error("int fell without write");
  AST_MISO_OE: assert property ($past(i_rstn) |-> o_miso_oe == !$past(i_cs_n))
    else $error("miso enable mismatch");
  AST_MISO_IDLE: assert property ($past(i_cs_n) && $past(i_cs_n, 2) |-> !o_miso)
    else $error("miso not low when idle");
  AST_CFG_HOLD: assert property (!$stable(o_cfg) |-> !$past(i_cs_n, 2) || !$past(i_cs_n, 3))
    else $error("config changed without write");
endmodule : uifl_regs_sva

bind uifl_regs uifl_regs_sva chk_u (.*);

// *** tb/uifl_host.sv ***
module uifl_host (
  // clock
  input  wire logic i_ref_clk,
  // serial port
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_mosi,
  input  wire logic i_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: deselected, clock still
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end
  // one access, address then data, msb first; odd address reads
  task automatic xfer(input logic [7:0] addr, input logic [7:0] data, output logic [7:0] rd);
    logic [15:0] w;
    w = {addr, data};
    rd = 8'h00;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge i_ref_clk);
      o_mosi <= w[i];
      o_sclk <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      if (i < 8) rd[i] = i_miso;
      o_sclk <= 1'b1;
      @(posedge i_ref_clk);
    end
    @(posedge i_ref_clk);
    o_sclk <= 1'b0;
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (2) @(posedge i_ref_clk);
  endtask : xfer
endmodule : uifl_host

// *** tb/testbench.sv ***
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import uifl_pkg::*;
  logic i_ref_clk, i_rstn, cs_n, sclk, mosi, miso, miso_oe;
  logic [7:0] rx_st, tx_st;
  logic rx_p, rx_m, tx_bit, rx_bit, tx_p, tx_m, o_int;
  uifl_cfg_s cfg;
  logic [15:0] per;
  int err_count, cmp_count, cycles;
  uifl_host host_u (.i_ref_clk(i_ref_clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi),
    .i_miso(miso));
  uifl_regs dut_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .i_rx_status(rx_st),
    .i_tx_status(tx_st), .i_rx_plus_in(rx_p), .i_rx_minus_in(rx_m), .i_tx_bit(tx_bit),
    .o_rx_bit(rx_bit), .o_tx_plus(tx_p), .o_tx_minus(tx_m), .o_cfg(cfg),
    .o_bit_period(per), .o_int(o_int));
  // clock and hang guard
  always #25 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host_u.xfer(a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host_u.xfer(a, 8'h00, q);
    `CHK(q, e)
  endtask : rd
  task automatic t_reset();
    rd(8'h09, 8'h00);
    rd(8'h0b, 8'h80);
    rd(8'h0d, 8'h60);
    rd(8'h11, 8'h00);
    `CHK(miso_oe, 1'b0)
    `CHK(o_int, 1'b0)
  endtask : t_reset
  task automatic t_cfg();
    logic [15:0] tbl [4] = '{16'h0028, 16'h0028, 16'h0014, 16'h000a};
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      v = {c[0], c[1:0], 5'h15 ^ 5'(c)};
      wr(8'h0c, v);
      rd(8'h0d, v);
      rx_p <= 1'b0;
      rx_m <= 1'b0;
      tx_bit <= c[1];
      repeat (3) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      `CHK(cfg, v)
      `CHK(per, tbl[c])
      `CHK(rx_bit, 1'(c[0]))
      `CHK({tx_p, tx_m}, {1'(c[1]), ~1'(c[1])})
      @(posedge i_ref_clk);
      rx_m <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      `CHK(rx_bit, 1'b0)
      @(posedge i_ref_clk);
    end
  endtask : t_cfg
  task automatic t_flags();
    wr(8'h06, 8'hff);
    rd(8'h07, 8'h3f);
    `CHK(o_int, 1'b0)
    rx_st <= 8'hff;
    tx_st <= 8'hff;
    repeat (3) @(posedge i_ref_clk);
    `CHK(o_int, 1'b1)
    rd(8'h09, 8'hbf);
    rd(8'h0b, 8'hbf);
    wr(8'h0a, 8'h80);
    `CHK(o_int, 1'b0)
    rd(8'h0b, 8'h80);
    wr(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    wr(8'h04, 8'h01);
    `CHK(o_int, 1'b1)
    rd(8'h05, 8'h01);
    wr(8'h08, 8'hfe);
    `CHK(o_int, 1'b0)
    rd(8'h09, 8'hbe);
  endtask : t_flags
  // reset, then the scenarios in turn
  initial begin
    i_ref_clk = 1'b0;
    i_rstn = 1'b0;
    {rx_st, tx_st} = 16'h0000;
    {rx_p, rx_m, tx_bit} = 3'h0;
    repeat (20) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_cfg();
    t_flags();
    results();
  end
endmodule : testbench
